// *** rtl/smc_top.sv ***
// Supervisor memory control: linkage, block invalidate, segments, TLB ops
`timescale 1ns/1ps
module smc_top (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_op_valid,
  output logic o_op_ready,
  input wire smc_pkg::smc_op_t i_op_code,
  input wire logic [31:0] i_op_ea,
  input wire logic [31:0] i_op_data,
  input wire logic [3:0] i_op_sr,
  output logic o_op_done,
  output logic [31:0] o_op_rdata,
  output logic o_exc_valid,
  output smc_pkg::smc_exc_t o_exc_cause,
  output logic o_xlat_req,
  output logic [31:0] o_xlat_ea,
  output logic o_xlat_store,
  input wire logic i_xlat_ack,
  input wire logic i_xlat_bat_prot_fault,
  input wire logic i_xlat_page_prot_fault,
  input wire logic i_xlat_direct_store,
  input wire logic [31:0] i_xlat_pa,
  output logic o_dc_look_req,
  output logic [31:0] o_dc_pa,
  input wire logic i_dc_ack,
  input wire logic i_dc_hit,
  input wire logic [2:0] i_dc_way,
  output logic o_dc_inv,
  output logic [6:0] o_dc_inv_set,
  output logic [2:0] o_dc_inv_way,
  output logic o_bus_inv_req,
  output logic [31:0] o_bus_inv_pa,
  input wire logic i_bus_inv_ack,
  output logic o_tlb_inv,
  output logic [5:0] o_tlb_inv_set,
  output logic o_sr_wr,
  output logic [3:0] o_sr_idx,
  output logic [31:0] o_sr_wdata,
  output logic o_drain_req,
  input wire logic i_pipe_drained,
  input wire logic [31:0] i_rfi_target,
  output logic o_arch_restore,
  output logic o_fetch_redirect,
  output logic [31:0] o_fetch_pc,
  input wire logic i_translation_invalidate_sync_in_n,
  output logic o_irq,
  input wire logic [smc_pkg::SMC_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [smc_pkg::SMC_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  import smc_pkg::*;

  smc_state_t state_q, state_d;
  smc_op_t op_q;
  logic [31:0] ea_q;
  logic [31:0] pa_q;
  logic [31:0] sr_arch_q [16];
  logic [31:0] sr_shadow_q [16];
  logic [1:0] ctrl_q;
  logic [SMC_EV_W-1:0] ist_q;
  logic [SMC_EV_W-1:0] imask_q;
  logic [SMC_EV_W-1:0] ev;
  logic sync_meta_q, sync_n_q;
  logic [SMC_ADDR_W-1:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q, w_have_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic done_q, exc_q, dcinv_q, tlbinv_q, srwr_q, restore_q, redirect_q;
  logic [31:0] rdata_op_q;
  smc_exc_t cause_q;
  logic [6:0] inv_set_q;
  logic [2:0] inv_way_q;
  logic [5:0] tlb_set_q;
  logic [3:0] sr_idx_q;
  logic [31:0] sr_wdata_q, fetch_pc_q;

  // Decoded request handshake
  wire take_op = i_ce && i_op_valid && o_op_ready;
  wire is_mt = (i_op_code == SMC_OP_MTSR) || (i_op_code == SMC_OP_MTSRIN);
  wire is_mf = (i_op_code == SMC_OP_MFSR) || (i_op_code == SMC_OP_MFSRIN);
  wire indirect = (i_op_code == SMC_OP_MTSRIN) ||
                  (i_op_code == SMC_OP_MFSRIN);
  // Index from rB high nibble for the indirect forms
  wire [3:0] sr_sel = indirect ? i_op_ea[31:SMC_SR_IDX_LO] : i_op_sr;
  wire shadow_sel = ctrl_q[SMC_CTRL_SHADOW_BIT];
  wire [31:0] sr_read = shadow_sel ? sr_shadow_q[sr_sel]
                                   : sr_arch_q[sr_sel];
  wire known_op = (i_op_code <= SMC_OP_TLBSYNC);

  // Block and page protection faults are merged: either one raises the same DSI
  wire xlat_fault = i_xlat_bat_prot_fault || i_xlat_page_prot_fault;
  wire xlat_done = i_ce && (state_q == SMC_ST_XLAT) && i_xlat_ack;
  wire look_done = i_ce && (state_q == SMC_ST_LOOK) && i_dc_ack;
  wire bcast_done = i_ce && (state_q == SMC_ST_BCAST) && i_bus_inv_ack;
  wire bcast_on = ctrl_q[SMC_CTRL_ABE_BIT];
  wire sync_idle = sync_n_q;
  wire finish = look_done && !bcast_on ||
                bcast_done ||
                xlat_done && (xlat_fault || i_xlat_direct_store) ||
                (state_q == SMC_ST_SYNC) && i_ce && sync_idle ||
                (state_q == SMC_ST_DRAIN) && i_ce && i_pipe_drained;

  assign o_op_ready = (state_q == SMC_ST_IDLE) && !done_q;
  assign o_xlat_req = (state_q == SMC_ST_XLAT);
  assign o_xlat_ea = ea_q;
  assign o_xlat_store = 1'b1;
  assign o_dc_look_req = (state_q == SMC_ST_LOOK);
  assign o_dc_pa = pa_q;
  assign o_bus_inv_req = (state_q == SMC_ST_BCAST);
  assign o_bus_inv_pa = pa_q;
  assign o_drain_req = (state_q == SMC_ST_DRAIN);

  always_comb begin
    state_d = state_q;
    case (state_q)
      SMC_ST_IDLE: begin
        if (take_op && i_op_code == SMC_OP_DCBI) begin
          state_d = SMC_ST_XLAT;
        end else if (take_op && i_op_code == SMC_OP_RFI) begin
          state_d = SMC_ST_DRAIN;
        end else if (take_op && i_op_code == SMC_OP_TLBSYNC) begin
          state_d = SMC_ST_SYNC;
        end
      end
      SMC_ST_XLAT: begin
        if (xlat_done) begin
          // Faults and direct-store end the op without a lookup
          state_d = (xlat_fault || i_xlat_direct_store) ? SMC_ST_IDLE
                                                        : SMC_ST_LOOK;
        end
      end
      SMC_ST_LOOK: begin
        if (look_done) begin
          state_d = bcast_on ? SMC_ST_BCAST : SMC_ST_IDLE;
        end
      end
      SMC_ST_BCAST: begin
        if (bcast_done) begin
          state_d = SMC_ST_IDLE;
        end
      end
      SMC_ST_DRAIN: begin
        if (i_ce && i_pipe_drained) begin
          state_d = SMC_ST_IDLE;
        end
      end
      SMC_ST_SYNC: begin
        if (i_ce && sync_idle) begin
          state_d = SMC_ST_IDLE;
        end
      end
      default: state_d = SMC_ST_IDLE;
    endcase
  end

  // Sync pin is asynchronous to the core clock
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_meta_q <= 1'b1;
      sync_n_q <= 1'b1;
    end else if (i_ce) begin
      sync_meta_q <= i_translation_invalidate_sync_in_n;
      sync_n_q <= sync_meta_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= SMC_ST_IDLE;
      op_q <= SMC_OP_SC;
      ea_q <= 32'h0;
      pa_q <= 32'h0;
    end else if (i_ce) begin
      state_q <= state_d;
      if (take_op) begin
        op_q <= i_op_code;
        ea_q <= i_op_ea;
      end
      if (xlat_done) begin
        pa_q <= i_xlat_pa;
      end
    end
  end

  // Segment moves never look at the relocation enables
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 16; i++) begin
        sr_arch_q[i] <= 32'h0;
        sr_shadow_q[i] <= 32'h0;
      end
    end else if (i_ce && take_op && is_mt) begin
      sr_arch_q[sr_sel] <= i_op_data;
      sr_shadow_q[sr_sel] <= i_op_data;
    end
  end

  // Pulse outputs and per-op results
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_q <= 1'b0;
      exc_q <= 1'b0;
      cause_q <= SMC_EXC_SYSCALL;
      rdata_op_q <= 32'h0;
      dcinv_q <= 1'b0;
      inv_set_q <= 7'h00;
      inv_way_q <= 3'h0;
      tlbinv_q <= 1'b0;
      tlb_set_q <= 6'h00;
      srwr_q <= 1'b0;
      sr_idx_q <= 4'h0;
      sr_wdata_q <= 32'h0;
      restore_q <= 1'b0;
      redirect_q <= 1'b0;
      fetch_pc_q <= 32'h0;
    end else if (i_ce) begin
      done_q <= (take_op && state_d == SMC_ST_IDLE) || finish;
      exc_q <= 1'b0;
      dcinv_q <= 1'b0;
      tlbinv_q <= 1'b0;
      srwr_q <= 1'b0;
      redirect_q <= restore_q;
      restore_q <= 1'b0;
      if (take_op) begin
        rdata_op_q <= is_mf ? sr_read : 32'h0;
      end
      if (take_op && i_op_code == SMC_OP_SC) begin
        exc_q <= 1'b1;
        cause_q <= SMC_EXC_SYSCALL;
      end
      if (take_op && (!known_op || i_op_code == SMC_OP_TLBIA)) begin
        exc_q <= 1'b1;
        cause_q <= SMC_EXC_PROGRAM;
      end
      if (xlat_done && xlat_fault) begin
        exc_q <= 1'b1;
        cause_q <= SMC_EXC_DSI;
      end
      // No enable or lock gate: invalidate applies in every cache mode
      if (look_done && i_dc_hit) begin
        dcinv_q <= 1'b1;
        inv_set_q <= pa_q[SMC_SET_HI:SMC_SET_LO];
        inv_way_q <= i_dc_way;
      end
      if (take_op && i_op_code == SMC_OP_TLBIE) begin
        tlbinv_q <= 1'b1;
        tlb_set_q <= i_op_ea[SMC_TLB_IDX_HI:SMC_TLB_IDX_LO];
      end
      if (take_op && is_mt) begin
        srwr_q <= 1'b1;
        sr_idx_q <= sr_sel;
        sr_wdata_q <= i_op_data;
      end
      if (state_q == SMC_ST_DRAIN && i_pipe_drained) begin
        restore_q <= 1'b1;
        fetch_pc_q <= i_rfi_target;
      end
    end
  end

  assign o_op_done = done_q;
  assign o_op_rdata = rdata_op_q;
  assign o_exc_valid = exc_q;
  assign o_exc_cause = cause_q;
  assign o_dc_inv = dcinv_q;
  assign o_dc_inv_set = inv_set_q;
  assign o_dc_inv_way = inv_way_q;
  assign o_tlb_inv = tlbinv_q;
  assign o_tlb_inv_set = tlb_set_q;
  assign o_sr_wr = srwr_q;
  assign o_sr_idx = sr_idx_q;
  assign o_sr_wdata = sr_wdata_q;
  assign o_arch_restore = restore_q;
  assign o_fetch_redirect = redirect_q;
  assign o_fetch_pc = fetch_pc_q;

  // Events for the sticky status
  assign ev[SMC_EV_SYSCALL] = take_op && i_op_code == SMC_OP_SC;
  assign ev[SMC_EV_DSI] = xlat_done && xlat_fault;
  assign ev[SMC_EV_PROGRAM] = take_op &&
                              (!known_op || i_op_code == SMC_OP_TLBIA);
  assign ev[SMC_EV_SYNC_DONE] = (state_q == SMC_ST_SYNC) && i_ce && sync_idle;
  assign ev[SMC_EV_INV_HIT] = look_done && i_dc_hit;

  // AXI4-Lite slave, one outstanding write and one read
  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire wr_ctrl = (awaddr_q == SMC_OFF_CTRL);
  wire wr_ist = (awaddr_q == SMC_OFF_INT_STAT);
  wire wr_mask = (awaddr_q == SMC_OFF_INT_MASK);
  wire wr_ok = wr_ctrl || wr_ist || wr_mask ||
               (awaddr_q == SMC_OFF_STATUS);
  wire [31:0] status_word = {27'h0, sync_n_q, 1'b0, state_q};
  wire [31:0] rd_word =
    (araddr_q == SMC_OFF_CTRL) ? {30'h0, ctrl_q} :
    (araddr_q == SMC_OFF_STATUS) ? status_word :
    (araddr_q == SMC_OFF_INT_STAT) ? {27'h0, ist_q} :
    (araddr_q == SMC_OFF_INT_MASK) ? {27'h0, imask_q} : 32'h0;
  wire rd_ok = (araddr_q == SMC_OFF_CTRL) || (araddr_q == SMC_OFF_STATUS) ||
               (araddr_q == SMC_OFF_INT_STAT) ||
               (araddr_q == SMC_OFF_INT_MASK);
  logic ar_have_q;
  wire [SMC_EV_W-1:0] w1c = (do_write && wr_ist && wstrb_q[0]) ?
                            wdata_q[SMC_EV_W-1:0] : SMC_EV_RST;

  assign o_awready = i_ce && !aw_have_q;
  assign o_wready = i_ce && !w_have_q;
  assign o_arready = i_ce && !ar_have_q && !rvalid_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign o_irq = |(ist_q & imask_q);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= SMC_RESP_OKAY;
    end else if (i_ce) begin
      if (i_awvalid && o_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= {i_awaddr[SMC_ADDR_W-1:2], 2'b00};
      end
      if (i_wvalid && o_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
      end
      if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ar_have_q <= 1'b0;
      araddr_q <= '0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= SMC_RESP_OKAY;
    end else if (i_ce) begin
      if (i_arvalid && o_arready) begin
        ar_have_q <= 1'b1;
        araddr_q <= {i_araddr[SMC_ADDR_W-1:2], 2'b00};
      end
      if (ar_have_q && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_ok ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
        ar_have_q <= 1'b0;
      end
      if (rvalid_q && i_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= SMC_CTRL_RST;
      ist_q <= SMC_EV_RST;
      imask_q <= SMC_EV_RST;
    end else if (i_ce) begin
      ist_q <= (ist_q & ~w1c) | ev;
      if (do_write && wr_ctrl && wstrb_q[0]) begin
        ctrl_q <= wdata_q[1:0];
      end
      if (do_write && wr_mask && wstrb_q[0]) begin
        imask_q <= wdata_q[SMC_EV_W-1:0];
      end
    end
  end
endmodule

// *** rtl/smc_pkg.sv ***
// Shared constants and types of the supervisor memory control block
package smc_pkg;
  localparam int SMC_ADDR_W = 8;
  localparam logic [7:0] SMC_OFF_CTRL = 8'h00;
  localparam logic [7:0] SMC_OFF_STATUS = 8'h04;
  localparam logic [7:0] SMC_OFF_INT_STAT = 8'h08;
  localparam logic [7:0] SMC_OFF_INT_MASK = 8'h0C;
  localparam logic [1:0] SMC_CTRL_RST = 2'h0;
  localparam int SMC_CTRL_ABE_BIT = 0;
  localparam int SMC_CTRL_SHADOW_BIT = 1;
  localparam int SMC_EV_W = 5;
  localparam int SMC_EV_SYSCALL = 0;
  localparam int SMC_EV_DSI = 1;
  localparam int SMC_EV_PROGRAM = 2;
  localparam int SMC_EV_SYNC_DONE = 3;
  localparam int SMC_EV_INV_HIT = 4;
  localparam logic [SMC_EV_W-1:0] SMC_EV_RST = 5'h00;
  localparam int SMC_TLB_IDX_LO = 12;
  localparam int SMC_TLB_IDX_HI = 17;
  localparam int SMC_SR_IDX_LO = 28;
  localparam int SMC_SET_LO = 5;
  localparam int SMC_SET_HI = 11;
  localparam logic [1:0] SMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SMC_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SMC_OP_SC = 4'h0,
    SMC_OP_RFI = 4'h1,
    SMC_OP_DCBI = 4'h2,
    SMC_OP_MTSR = 4'h3,
    SMC_OP_MTSRIN = 4'h4,
    SMC_OP_MFSR = 4'h5,
    SMC_OP_MFSRIN = 4'h6,
    SMC_OP_TLBIE = 4'h7,
    SMC_OP_TLBSYNC = 4'h8,
    SMC_OP_TLBIA = 4'h9
  } smc_op_t;

  typedef enum logic [2:0] {
    SMC_ST_IDLE = 3'h0,
    SMC_ST_XLAT = 3'h1,
    SMC_ST_LOOK = 3'h3,
    SMC_ST_BCAST = 3'h2,
    SMC_ST_DRAIN = 3'h6,
    SMC_ST_SYNC = 3'h7
  } smc_state_t;

  typedef enum logic [1:0] {
    SMC_EXC_SYSCALL = 2'h0,
    SMC_EXC_DSI = 2'h1,
    SMC_EXC_PROGRAM = 2'h2
  } smc_exc_t;
endpackage

// *** tb/smc_chk.sv ***
// Port-level property checker for the supervisor memory control block
`timescale 1ns/1ps
module smc_chk (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_op_valid,
  input wire logic o_op_ready,
  input wire smc_pkg::smc_op_t i_op_code,
  input wire logic [31:0] i_op_ea,
  input wire logic o_op_done,
  input wire logic o_exc_valid,
  input wire smc_pkg::smc_exc_t o_exc_cause,
  input wire logic o_xlat_req,
  input wire logic o_xlat_store,
  input wire logic i_xlat_ack,
  input wire logic i_xlat_bat_prot_fault,
  input wire logic i_xlat_page_prot_fault,
  input wire logic i_xlat_direct_store,
  input wire logic o_dc_look_req,
  input wire logic [31:0] o_dc_pa,
  input wire logic i_dc_ack,
  input wire logic i_dc_hit,
  input wire logic [2:0] i_dc_way,
  input wire logic o_dc_inv,
  input wire logic [6:0] o_dc_inv_set,
  input wire logic [2:0] o_dc_inv_way,
  input wire logic o_tlb_inv,
  input wire logic [5:0] o_tlb_inv_set,
  input wire logic o_arch_restore,
  input wire logic o_fetch_redirect
);
  import smc_pkg::*;
  logic tk, xa, flt;
  logic [5:0] ea_set;
  assign tk = i_ce & i_op_valid & o_op_ready;
  assign xa = o_xlat_req & i_xlat_ack;
  assign flt = i_xlat_bat_prot_fault | i_xlat_page_prot_fault;
  assign ea_set = i_op_ea[17:12];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  chk_sc_trap: assert property (
    tk && i_op_code == SMC_OP_SC |=> o_op_done && o_exc_valid
    && o_exc_cause == SMC_EXC_SYSCALL) else $error("sc gave no trap");
  chk_tlbia_illegal: assert property (
    tk && i_op_code == SMC_OP_TLBIA |=> o_exc_valid
    && o_exc_cause == SMC_EXC_PROGRAM) else $error("tlbia not illegal");
  chk_tlbie_set: assert property (
    tk && i_op_code == SMC_OP_TLBIE |=> o_tlb_inv
    && o_tlb_inv_set == $past(ea_set)) else $error("tlbie set wrong");
  chk_inv_as_store: assert property (
    tk && i_op_code == SMC_OP_DCBI |=> o_xlat_req && o_xlat_store)
    else $error("dcbi not translated as store");
  chk_fault_dsi: assert property (
    xa && flt |=> o_exc_valid && o_exc_cause == SMC_EXC_DSI && o_op_done
    && !o_dc_inv) else $error("fault gave no DSI");
  chk_dstore_noop: assert property (
    xa && !flt && i_xlat_direct_store |=> o_op_done && !o_exc_valid
    && !o_dc_inv ##1 !o_dc_look_req) else $error("direct-store not no-op");
  chk_hit_inv: assert property (
    o_dc_look_req && i_dc_ack && i_dc_hit |=> o_dc_inv
    && o_dc_inv_way == $past(i_dc_way) && o_dc_inv_set == o_dc_pa[11:5])
    else $error("hit not invalidated");
  chk_miss_quiet: assert property (
    o_dc_look_req && i_dc_ack && !i_dc_hit |=> !o_dc_inv)
    else $error("miss touched cache");
  chk_rfi_order: assert property (
    o_arch_restore |-> o_op_done ##1 o_fetch_redirect && !o_arch_restore)
    else $error("rfi order wrong");
  cover property (o_dc_inv);
  cover property (o_fetch_redirect);
  cover property (xa && flt);
endmodule

// *** tb/smc_top_tb.sv ***
// Directed bench for the supervisor memory control block
`timescale 1ns/1ps
module smc_top_tb;
  import smc_pkg::*;
  logic i_clk, i_arst_n, i_ce, i_op_valid, i_xlat_ack, i_dc_ack, i_dc_hit;
  logic i_xlat_bat_prot_fault, i_xlat_page_prot_fault, i_xlat_direct_store;
  logic i_bus_inv_ack, i_pipe_drained, i_translation_invalidate_sync_in_n;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [31:0] i_op_ea, i_op_data, i_xlat_pa, i_rfi_target, i_wdata;
  logic [3:0] i_op_sr, i_wstrb, rq;
  logic [2:0] i_dc_way;
  logic [7:0] i_awaddr, i_araddr, seen;
  smc_op_t i_op_code;
  logic o_op_ready, o_op_done, o_exc_valid, o_xlat_req, o_xlat_store;
  logic o_dc_look_req, o_dc_inv, o_bus_inv_req, o_tlb_inv, o_sr_wr, o_irq;
  logic o_drain_req, o_arch_restore, o_fetch_redirect, o_awready, o_wready;
  logic o_bvalid, o_arready, o_rvalid;
  logic [31:0] o_op_rdata, o_xlat_ea, o_dc_pa, o_bus_inv_pa, o_sr_wdata;
  logic [31:0] o_fetch_pc, o_rdata;
  logic [6:0] o_dc_inv_set;
  logic [5:0] o_tlb_inv_set;
  logic [3:0] o_sr_idx;
  logic [2:0] o_dc_inv_way;
  logic [1:0] o_bresp, o_rresp;
  smc_exc_t o_exc_cause;
  int miscompares, checks, cyc, sync_cnt, t0;

  smc_top u_dut (.*);

  always #2.5 i_clk = ~i_clk;

  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // Outputs are sampled mid-cycle so that no edge race decides a result
  always @(negedge i_clk) begin
    seen = seen | {o_op_done, o_exc_valid, o_dc_inv, o_tlb_inv, o_sr_wr,
      o_arch_restore, o_fetch_redirect, o_bus_inv_req & i_bus_inv_ack};
    rq = {o_xlat_req & !i_xlat_ack, o_dc_look_req & !i_dc_ack,
      o_bus_inv_req & !i_bus_inv_ack, o_drain_req & !i_pipe_drained};
  end

  always @(posedge i_clk) begin
    {i_xlat_ack, i_dc_ack, i_bus_inv_ack, i_pipe_drained} <= rq;
    cyc <= cyc + 1;
    if (sync_cnt == 1) i_translation_invalidate_sync_in_n <= 1'b1;
    if (sync_cnt != 0) sync_cnt <= sync_cnt - 1;
    if (cyc == 5000) begin
      miscompares++;
      close_out;
    end
  end

  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    logic [1:0] r;
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    // Let an edge pass after release so back-to-back calls never re-drive
    bh = 1'b0;
    while (!bh) begin
      @(negedge i_clk);
      ah = o_awready & i_awvalid;
      wh = o_wready & i_wvalid;
      bh = o_bvalid;
      r = o_bresp;
      @(posedge i_clk);
      if (ah) i_awvalid <= 1'b0;
      if (wh) i_wvalid <= 1'b0;
    end
    i_bready <= 1'b0;
    @(posedge i_clk);
    chk("bresp", SMC_RESP_OKAY, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er);
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] r;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge i_clk);
      ah = o_arready & i_arvalid;
      rh = o_rvalid;
      d = o_rdata;
      r = o_rresp;
      @(posedge i_clk);
      if (ah) i_arvalid <= 1'b0;
    end
    i_rready <= 1'b0;
    @(posedge i_clk);
    chk("rdata", ed, d);
    chk("rresp", er, r);
  endtask

  task automatic op(input smc_op_t c, input logic [31:0] ea, d);
    logic tk;
    i_op_code <= c;
    i_op_ea <= ea;
    i_op_data <= d;
    i_op_valid <= 1'b1;
    seen = 8'h00;
    tk = 1'b0;
    while (!tk) begin
      @(negedge i_clk);
      tk = o_op_ready;
      @(posedge i_clk);
    end
    i_op_valid <= 1'b0;
    while (!seen[7]) @(negedge i_clk);
    // Redirect trails completion by a cycle
    repeat (2) @(negedge i_clk);
    @(posedge i_clk);
  endtask

  initial begin
    {i_clk, i_arst_n, i_op_valid, i_dc_hit, i_xlat_bat_prot_fault} = 5'h00;
    {i_xlat_page_prot_fault, i_xlat_direct_store, i_awvalid} = 3'h0;
    {i_wvalid, i_bready, i_arvalid, i_rready, i_op_sr} = 8'h00;
    {i_op_ea, i_op_data, i_xlat_pa, i_wdata} = 128'h0;
    {i_dc_way, i_awaddr, i_araddr} = 19'h0;
    i_rfi_target = 32'h0000_0700;
    i_op_code = SMC_OP_SC;
    {i_ce, i_translation_invalidate_sync_in_n} = 2'h3;
    i_wstrb = 4'hF;
    {seen, rq, miscompares, checks, cyc, sync_cnt} = '0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    rdc(SMC_OFF_CTRL, 32'h0, SMC_RESP_OKAY);
    rdc(SMC_OFF_INT_MASK, 32'h0, SMC_RESP_OKAY);
    rdc(8'h10, 32'h0, SMC_RESP_SLVERR);
    $display("test registers done");
    op(SMC_OP_SC, 32'h0, 32'h0);
    chk("sc pulses", 8'hC0, seen);
    chk("sc cause", SMC_EXC_SYSCALL, o_exc_cause);
    op(SMC_OP_TLBIA, 32'h0, 32'h0);
    chk("tlbia cause", SMC_EXC_PROGRAM, o_exc_cause);
    op(smc_op_t'(4'hA), 32'h0, 32'h0);
    chk("illegal pulses", 8'hC0, seen);
    $display("test linkage done");
    for (int i = 0; i < 64; i++) begin
      op(SMC_OP_TLBIE, 32'hFFFC0FFF | (i << 12), 32'h0);
      chk("tlbie set", i, o_tlb_inv_set);
    end
    i_translation_invalidate_sync_in_n <= 1'b0;
    sync_cnt <= 10;
    t0 = cyc;
    // Pin needs two flops of latency before the wait can see it busy
    repeat (3) @(posedge i_clk);
    op(SMC_OP_TLBSYNC, 32'h0, 32'h0);
    chk("sync pulses", 8'h80, seen);
    chk("sync wait", 1, (cyc - t0) >= 11);
    $display("test tlb done");
    op(SMC_OP_MTSRIN, 32'h9000_0000, 32'h1234_5678);
    chk("sr pulses", 8'h88, seen);
    chk("sr idx", 4'h9, o_sr_idx);
    op(SMC_OP_MFSR, 32'h0, 32'h0);
    chk("sr other", 32'h0, o_op_rdata);
    wrc(SMC_OFF_CTRL, 32'h2);
    op(SMC_OP_MFSRIN, 32'h9000_0000, 32'h0);
    chk("shadow read", 32'h1234_5678, o_op_rdata);
    $display("test segments done");
    wrc(SMC_OFF_CTRL, 32'h0);
    wrc(SMC_OFF_INT_STAT, 32'h1F);
    i_xlat_pa <= 32'h0000_1FE0;
    i_dc_hit <= 1'b1;
    i_dc_way <= 3'h3;
    op(SMC_OP_DCBI, 32'h0000_1FE4, 32'h0);
    chk("hit pulses", 8'hA0, seen);
    chk("inv set", 7'h7F, o_dc_inv_set);
    chk("inv way", 3'h3, o_dc_inv_way);
    chk("irq masked", 1'b0, o_irq);
    wrc(SMC_OFF_INT_MASK, 32'h10);
    chk("irq", 1'b1, o_irq);
    wrc(SMC_OFF_INT_STAT, 32'h10);
    chk("irq cleared", 1'b0, o_irq);
    wrc(SMC_OFF_CTRL, 32'h1);
    i_dc_hit <= 1'b0;
    op(SMC_OP_DCBI, 32'h0000_1FE4, 32'h0);
    chk("miss pulses", 8'h81, seen);
    i_xlat_bat_prot_fault <= 1'b1;
    i_xlat_page_prot_fault <= 1'b1;
    op(SMC_OP_DCBI, 32'h0000_1FE4, 32'h0);
    chk("fault pulses", 8'hC0, seen);
    chk("fault cause", SMC_EXC_DSI, o_exc_cause);
    i_xlat_bat_prot_fault <= 1'b0;
    op(SMC_OP_DCBI, 32'h0000_1FE4, 32'h0);
    chk("page fault", 8'hC0, seen);
    i_xlat_page_prot_fault <= 1'b0;
    i_xlat_direct_store <= 1'b1;
    op(SMC_OP_DCBI, 32'h0000_1FE4, 32'h0);
    chk("dstore pulses", 8'h80, seen);
    $display("test block invalidate done");
    op(SMC_OP_RFI, 32'h0, 32'h0);
    chk("rfi pulses", 8'h86, seen);
    chk("rfi pc", 32'h0000_0700, o_fetch_pc);
    $display("test return done");
    close_out;
  end
endmodule

bind smc_top smc_chk u_chk (.i_clk, .i_arst_n, .i_ce, .i_op_valid,
  .o_op_ready, .i_op_code, .i_op_ea, .o_op_done, .o_exc_valid, .o_exc_cause,
  .o_xlat_req, .o_xlat_store, .i_xlat_ack, .i_xlat_bat_prot_fault,
  .i_xlat_page_prot_fault, .i_xlat_direct_store, .o_dc_look_req, .o_dc_pa,
  .i_dc_ack, .i_dc_hit, .i_dc_way, .o_dc_inv, .o_dc_inv_set, .o_dc_inv_way,
  .o_tlb_inv, .o_tlb_inv_set, .o_arch_restore, .o_fetch_redirect);
